// File: design/amd_pkg.sv
package amd_pkg;
   localparam int unsigned amd_addr_w = 16;
   localparam int unsigned amd_data_w = 8;
   // opcode-map page prebytes
   localparam logic [7:0] amd_pre_page2 = 8'h18;
   localparam logic [7:0] amd_pre_page3 = 8'h1a;
   localparam logic [7:0] amd_pre_page4 = 8'hcd;
   // page-1 opcodes
   localparam logic [7:0] amd_op_add_accumulators = 8'h1b;
   localparam logic [7:0] amd_op_increment_acc_b = 8'h5c;
   localparam logic [7:0] amd_op_increment_index_x = 8'h08;
   localparam logic [7:0] amd_op_add_b_to_index_x = 8'h3a;
   localparam logic [7:0] amd_op_swap_d_with_x = 8'h8f;
   localparam logic [7:0] amd_op_branch_always = 8'h20;
   localparam logic [7:0] amd_op_bset_dir = 8'h14;
   localparam logic [7:0] amd_op_bclr_dir = 8'h15;
   localparam logic [7:0] amd_op_branch_if_bits_set_dir = 8'h12;
   localparam logic [7:0] amd_op_branch_if_bits_clear_dir = 8'h13;
   localparam logic [7:0] amd_op_bset_idx = 8'h1c;
   localparam logic [7:0] amd_op_bclr_idx = 8'h1d;
   localparam logic [7:0] amd_op_branch_if_bits_set_idx = 8'h1e;
   localparam logic [7:0] amd_op_branch_if_bits_clear_idx = 8'h1f;
   localparam logic [7:0] amd_op_ldd_imm = 8'hcc;
   localparam logic [7:0] amd_op_ldd_dir = 8'hdc;
   localparam logic [7:0] amd_op_ldd_idx = 8'hec;
   localparam logic [7:0] amd_op_ldd_ext = 8'hfc;
   localparam logic [7:0] amd_op_std_dir = 8'hdd;
   localparam logic [7:0] amd_op_std_idx = 8'hed;
   localparam logic [7:0] amd_op_std_ext = 8'hfd;
   localparam logic [3:0] amd_branch_hi = 4'h2;
   localparam logic [7:0] amd_zero_page_hi = 8'h00;
   localparam logic [15:0] amd_pc_reset = 16'h0000;
   localparam logic [3:0] amd_len_one = 4'h1;
   localparam logic [3:0] amd_len_two = 4'h2;
   localparam logic [3:0] amd_len_three = 4'h3;
   localparam logic [3:0] amd_len_four = 4'h4;
   // address modes
   typedef enum logic [5:0] {
      amd_mode_inherent_mode = 6'b000001,
      amd_mode_immediate = 6'b000010,
      amd_mode_direct = 6'b000100,
      amd_mode_extended = 6'b001000,
      amd_mode_x_indexed_mode = 6'b010000,
      amd_mode_y_indexed_mode = 6'b100000
   } amd_mode_t;
   typedef enum logic [4:0] {
      amd_st_opcode = 5'b00001,
      amd_st_page = 5'b00010,
      amd_st_op1 = 5'b00100,
      amd_st_op2 = 5'b01000,
      amd_st_op3 = 5'b10000
   } amd_state_t;
endpackage : amd_pkg

// File: design/amd_decoder.sv
`timescale 1ns/1ns
module amd_decoder
   import amd_pkg::*;
(
   input wire logic sys_clk_i, // cpu clock
   input wire logic rstn_i, // sync reset, active low
   input wire logic byte_valid_i, // instruction byte present
   input wire logic [amd_pkg::amd_data_w-1:0] byte_i, // instruction byte
   input wire logic [amd_pkg::amd_addr_w-1:0] index_x_i, // index register x
   input wire logic [amd_pkg::amd_addr_w-1:0] index_y_i, // index register y
   input wire logic [amd_pkg::amd_data_w-1:0] acc_a_i, // accumulator a
   input wire logic [amd_pkg::amd_data_w-1:0] acc_b_i, // accumulator b
   input wire logic branch_cond_i, // branch condition true
   output logic byte_ready_o, // byte consumed
   output logic done_o, // instruction decoded, one-cycle pulse
   output logic [amd_pkg::amd_addr_w-1:0] pc_o, // program counter
   output logic [amd_pkg::amd_addr_w-1:0] ea_o, // effective address
   output logic ea_valid_o, // ea is an operand address
   output logic [5:0] mode_o, // one-hot address mode
   output logic [1:0] page_o, // opcode page minus one
   output logic [3:0] length_o, // instruction length in bytes
   output logic illegal_o, // encoding not decoded
   output logic [amd_pkg::amd_data_w-1:0] acc_a_o, // new accumulator a
   output logic [amd_pkg::amd_data_w-1:0] acc_b_o, // new accumulator b
   output logic [amd_pkg::amd_addr_w-1:0] index_x_o, // new index x
   output logic regs_we_o // register results valid, one-cycle pulse
);
   import amd_pkg::*;

   amd_state_t state_q, state_d;
   logic [1:0] page_q;
   logic [7:0] opc_q;
   logic [7:0] b1_q, b2_q;
   logic [3:0] len_q;
   logic [15:0] pc_q;
   logic [15:0] start_q;
   logic done_q;
   logic [15:0] ea_q;
   logic ea_valid_q;
   logic [5:0] mode_q;
   logic [3:0] length_q;
   logic illegal_q;
   logic [7:0] acc_a_q, acc_b_q;
   logic [15:0] index_x_q;
   logic regs_we_q;

   // opcode decode on the latched opcode and page; prebyte match on the incoming byte_i
   wire take = byte_valid_i;
   wire is_pre2 = byte_i == amd_pre_page2;
   wire is_pre3 = byte_i == amd_pre_page3;
   wire is_pre4 = byte_i == amd_pre_page4;
   wire is_pre = is_pre2 | is_pre3 | is_pre4;
   wire on_y = page_q == 2'd1;
   wire is_bsc_dir = opc_q == amd_op_bset_dir || opc_q == amd_op_bclr_dir;
   wire is_bsc_idx = opc_q == amd_op_bset_idx || opc_q == amd_op_bclr_idx;
   wire is_brb_dir = opc_q == amd_op_branch_if_bits_set_dir || opc_q == amd_op_branch_if_bits_clear_dir;
   wire is_brb_idx = opc_q == amd_op_branch_if_bits_set_idx || opc_q == amd_op_branch_if_bits_clear_idx;
   wire is_brb = is_brb_dir | is_brb_idx;
   wire is_rel = opc_q[7:4] == amd_branch_hi;
   wire is_ldd = opc_q == amd_op_ldd_imm || opc_q == amd_op_ldd_dir || opc_q == amd_op_ldd_idx ||
      opc_q == amd_op_ldd_ext;
   wire is_std = opc_q == amd_op_std_dir || opc_q == amd_op_std_idx || opc_q == amd_op_std_ext;
   wire is_idx = is_bsc_idx | is_brb_idx | opc_q == amd_op_ldd_idx | opc_q == amd_op_std_idx;
   wire is_dir = is_bsc_dir | is_brb_dir | opc_q == amd_op_ldd_dir | opc_q == amd_op_std_dir;
   wire is_ext = opc_q == amd_op_ldd_ext || opc_q == amd_op_std_ext;
   wire is_imm = opc_q == amd_op_ldd_imm;
   wire is_inh = opc_q == amd_op_add_accumulators || opc_q == amd_op_increment_acc_b ||
      opc_q == amd_op_increment_index_x || opc_q == amd_op_add_b_to_index_x ||
      opc_q == amd_op_swap_d_with_x;
   // page 1 covers everything; page 2 only y-indexed and the y swap
   wire known_p1 = is_inh | is_rel | is_ldd | is_std | is_bsc_dir | is_bsc_idx | is_brb;
   wire known_p2 = is_idx | opc_q == amd_op_swap_d_with_x;
   wire known = page_q == 2'd0 ? known_p1 : (on_y ? known_p2 : 1'b0);
   // operand bytes after the opcode
   wire [3:0] ops = is_inh ? 4'd0 :
      is_brb ? amd_len_three :
      (is_bsc_dir | is_bsc_idx) ? amd_len_two :
      (is_ext | is_imm) ? amd_len_two :
      amd_len_one;
   wire [3:0] total = ops + (page_q != 2'd0 ? amd_len_two : amd_len_one);

   // effective address
   wire [15:0] idx_reg = on_y ? index_y_i : index_x_i;
   wire [5:0] sel_mode = is_inh ? amd_mode_inherent_mode :
      is_imm ? amd_mode_immediate :
      is_dir ? amd_mode_direct :
      is_ext ? amd_mode_extended :
      is_idx ? (on_y ? amd_mode_y_indexed_mode : amd_mode_x_indexed_mode) : 6'h00;

   // sequencer: opcode state, a decode cycle, then one state per operand byte
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         amd_st_opcode:
            if (take)
               state_d = amd_st_page;
         amd_st_page:
            state_d = ops == 4'd0 ? amd_st_opcode : amd_st_op1;
         amd_st_op1:
            if (take)
               state_d = len_q + 4'd1 == ops ? amd_st_opcode : amd_st_op2;
         amd_st_op2:
            if (take)
               state_d = len_q + 4'd1 == ops ? amd_st_opcode : amd_st_op3;
         amd_st_op3:
            if (take)
               state_d = amd_st_opcode;
         default:
            state_d = amd_st_opcode;
      endcase
   end

   assign byte_ready_o = state_q != amd_st_page;
   assign done_o = done_q;
   assign pc_o = pc_q;
   assign ea_o = ea_q;
   assign ea_valid_o = ea_valid_q;
   assign mode_o = mode_q;
   assign page_o = page_q;
   assign length_o = length_q;
   assign illegal_o = illegal_q;
   assign acc_a_o = acc_a_q;
   assign acc_b_o = acc_b_q;
   assign index_x_o = index_x_q;
   assign regs_we_o = regs_we_q;

   wire opc_take = take && state_q == amd_st_opcode;
   wire fin_now = (state_q == amd_st_page && ops == 4'd0) ||
      (take && (state_q == amd_st_op1 || state_q == amd_st_op2 || state_q == amd_st_op3) &&
       len_q + 4'd1 == ops);
   logic pre_pending_q;
   logic [1:0] pend_page_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         state_q <= amd_st_opcode;
         pc_q <= amd_pc_reset;
         start_q <= amd_pc_reset;
         page_q <= 2'd0;
         pend_page_q <= 2'd0;
         pre_pending_q <= 1'b0;
         opc_q <= 8'h00;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         len_q <= 4'd0;
      end
      else
      begin
         if (opc_take && is_pre && !pre_pending_q)
         begin
            pre_pending_q <= 1'b1;
            pend_page_q <= is_pre2 ? 2'd1 : is_pre3 ? 2'd2 : 2'd3;
            start_q <= pc_q;
            pc_q <= 16'(pc_q + 16'h0001);
         end
         else
         begin
            state_q <= state_d;
            if (opc_take)
            begin
               // a prebyte covers only this one opcode
               page_q <= pre_pending_q ? pend_page_q : 2'd0;
               pre_pending_q <= 1'b0;
               if (!pre_pending_q)
                  start_q <= pc_q;
               opc_q <= byte_i;
               len_q <= 4'd0;
               pc_q <= 16'(pc_q + 16'h0001);
            end
            else if (take && state_q != amd_st_page)
            begin
               if (state_q == amd_st_op1)
                  b1_q <= byte_i;
               else if (state_q == amd_st_op2 && !is_brb)
                  b2_q <= byte_i;
               else if (state_q == amd_st_op3 || (state_q == amd_st_op2 && is_brb))
                  b2_q <= state_q == amd_st_op3 ? byte_i : b2_q;
               len_q <= 4'(len_q + 4'd1);
               pc_q <= fin_now ? fin_pc(16'(pc_q + 16'h0001)) : 16'(pc_q + 16'h0001);
            end
            else if (fin_now)
               pc_q <= pc_q;
         end
      end
   end

   // branch target from the pc that sits after the final byte
   function automatic logic [15:0] fin_pc(input logic [15:0] after);
      logic [7:0] d;
      d = is_brb ? byte_i : (is_rel ? byte_i : 8'h00);
      if ((is_rel | is_brb) && branch_cond_i)
         fin_pc = 16'(after + {{8{d[7]}}, d});
      else
         fin_pc = after;
   endfunction : fin_pc

   // results latched at instruction end
   wire [7:0] fin_b1 = state_q == amd_st_op1 ? byte_i : b1_q;
   wire [7:0] fin_b2 = byte_i;
   wire [15:0] fin_idx = 16'(idx_reg + {8'h00, fin_b1});
   wire [15:0] fin_ea = is_idx ? fin_idx : is_dir ? {amd_zero_page_hi, fin_b1} :
      is_ext ? {b1_q, fin_b2} : 16'h0000;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         done_q <= 1'b0;
         ea_q <= 16'h0000;
         ea_valid_q <= 1'b0;
         mode_q <= 6'h00;
         length_q <= 4'd0;
         illegal_q <= 1'b0;
         regs_we_q <= 1'b0;
         acc_a_q <= 8'h00;
         acc_b_q <= 8'h00;
         index_x_q <= 16'h0000;
      end
      else
      begin
         done_q <= fin_now;
         regs_we_q <= fin_now && is_inh && known;
         if (fin_now)
         begin
            ea_q <= fin_ea;
            ea_valid_q <= known && (is_idx | is_dir | is_ext);
            mode_q <= known ? sel_mode : 6'h00;
            length_q <= total;
            illegal_q <= !known;
            acc_a_q <= opc_q == amd_op_add_accumulators ? 8'(acc_a_i + acc_b_i) : acc_a_i;
            acc_b_q <= opc_q == amd_op_increment_acc_b ? 8'(acc_b_i + 8'h01) : acc_b_i;
            index_x_q <= opc_q == amd_op_increment_index_x ? 16'(index_x_i + 16'h0001) :
               opc_q == amd_op_add_b_to_index_x ? 16'(index_x_i + {8'h00, acc_b_i}) : index_x_i;
         end
      end
   end

   a_idx_ea_sum: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      fin_now && known && is_idx |=> ea_q == 16'($past(idx_reg) + {8'h00, $past(fin_b1)}))
      else $error("indexed address wrong");
   a_dir_page: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && mode_q == amd_mode_direct |-> ea_q[15:8] == amd_zero_page_hi)
      else $error("direct high byte not zero");
   a_inh_no_ea: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && mode_q == amd_mode_inherent_mode |-> !ea_valid_q && length_q <= amd_len_two)
      else $error("inherent fetched operand");
   a_y_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && mode_q == amd_mode_y_indexed_mode |-> length_q >= amd_len_three)
      else $error("y form not longer");
   a_idx_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && mode_q == amd_mode_x_indexed_mode && !$past(is_brb) && !$past(is_bsc_idx)
      |-> length_q == amd_len_two)
      else $error("indexed length wrong");
   a_no_bsc_ext: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && mode_q == amd_mode_extended |-> $past(!is_bsc_dir && !is_bsc_idx && !is_brb))
      else $error("bit op extended");
   a_prebyte_once: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      opc_take && !pre_pending_q && !is_pre |=> page_q == 2'd0)
      else $error("stale prebyte page");
   a_inc_b: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      fin_now && opc_q == amd_op_increment_acc_b |=> acc_b_q == 8'($past(acc_b_i) + 8'h01))
      else $error("b increment wrong");
   a_branch_pc: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      fin_now && is_rel && known && !branch_cond_i && page_q == 2'd0 |=> pc_q == 16'($past(pc_q) + 16'h0001))
      else $error("untaken branch moved pc");

   // opcode accepted; a leading prebyte does not count
   sequence s_opcode_in;
      opc_take && !(is_pre && !pre_pending_q);
   endsequence
   sequence s_prebyte_in;
      opc_take && is_pre && !pre_pending_q;
   endsequence
   // decode cycle: the bus is refused while ops settle
   sequence s_decode_gap;
      state_q == amd_st_page && !byte_ready_o;
   endsequence
   sequence s_branch_end;
      fin_now && (is_rel || is_brb) && known;
   endsequence
   sequence s_branch_taken;
      fin_now && (is_rel || is_brb) && known && branch_cond_i;
   endsequence

   a_opcode_gap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_opcode_in |=> s_decode_gap)
      else $error("no decode gap after opcode");
   a_opcode_step: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_opcode_in |=> pc_q == 16'($past(pc_q) + 16'h0001))
      else $error("opcode fetch did not advance pc");
   a_prebyte_step: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_prebyte_in |=> byte_ready_o && state_q == amd_st_opcode && pc_q == 16'($past(pc_q) + 16'h0001))
      else $error("prebyte not followed by opcode fetch");
   a_page_select: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_prebyte_in ##1 s_opcode_in |=> page_q == ($past(byte_i, 2) == amd_pre_page2 ? 2'd1 :
      $past(byte_i, 2) == amd_pre_page3 ? 2'd2 : 2'd3))
      else $error("prebyte chose wrong page");
   a_inh_no_fetch: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_opcode_in ##1 (state_q == amd_st_page && is_inh) |=> done_q && !ea_valid_q)
      else $error("inherent op waited for operand");
   a_rel_length: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && !illegal_q && $past(is_rel) |-> length_q == amd_len_two)
      else $error("branch length wrong");
   // targets are reckoned from the pc that follows the final byte
   a_rel_target: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_branch_taken |=>
      pc_q == 16'($past(pc_q) + 16'h0001 + {{8{$past(byte_i[7])}}, $past(byte_i)}))
      else $error("branch target wrong");
   a_zero_disp: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_branch_end ##0 (byte_i == 8'h00) |=> pc_q == 16'($past(pc_q) + 16'h0001))
      else $error("zero displacement moved pc");
   // minus the length lands on the first byte, prebyte included
   a_self_loop: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      s_branch_taken ##0 (8'(byte_i + 8'(total)) == 8'h00) |=> pc_q == $past(start_q))
      else $error("branch to self missed");
   a_index_kept: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      fin_now && is_idx |=> index_x_q == $past(index_x_i) && !regs_we_q)
      else $error("indexed op changed index");
   a_ext_order: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      fin_now && is_ext && known |=> ea_q == {$past(b1_q), $past(byte_i)})
      else $error("extended address order wrong");
   a_imm_load_only: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q && mode_q == amd_mode_immediate |-> $past(opc_q) == amd_op_ldd_imm)
      else $error("immediate form not a double load");
endmodule : amd_decoder

// File: design/amd_unused.sv
`timescale 1ns/1ns

// File: sim/amd_mem_model.sv
`timescale 1ns/1ns
// instruction memory on the fetch side; offers only the bytes it was granted
module amd_mem_model
(
   input wire logic sys_clk_i, // cpu clock
   input wire logic rstn_i, // sync reset, active low
   input wire logic [15:0] pc_i, // fetch address
   input wire logic ready_i, // byte consumed
   input wire logic slow_i, // insert random stalls
   output logic valid_o, // byte present
   output logic [7:0] byte_o // byte at fetch address
);
   logic [7:0] mem [0:65535];
   int left = 0;
   logic tk;
   initial valid_o = 1'b0;
   initial byte_o = 8'h00;
   always @(posedge sys_clk_i)
   begin
      tk = valid_o & ready_i;
      if (tk)
         left = left - 1;
      #1;
      if (!rstn_i)
         valid_o = 1'b0;
      else if (!valid_o || tk)
         valid_o = (left > 0) && !(slow_i && $urandom_range(0, 1) == 0);
      // idle data toggles so a stale byte never looks valid
      byte_o = valid_o ? mem[pc_i] : ~byte_o;
   end
endmodule : amd_mem_model

// File: sim/test_cpu_address_mode_decoder.sv
`timescale 1ns/1ns
module test_cpu_address_mode_decoder;
   import amd_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] index_x_i = 16'h0000;
   logic [15:0] index_y_i = 16'h0000;
   logic [7:0] acc_a_i = 8'h00;
   logic [7:0] acc_b_i = 8'h00;
   logic branch_cond_i = 1'b0;
   logic slow = 1'b0;
   logic byte_valid, byte_ready, done_o, ea_valid_o, illegal_o, regs_we_o;
   logic [7:0] byte_d, acc_a_o, acc_b_o;
   logic [15:0] pc_o, ea_o, index_x_o;
   logic [5:0] mode_o;
   logic [1:0] page_o;
   logic [3:0] length_o;
   logic [15:0] pc_exp = 16'h0000;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   amd_decoder amd_decoder_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .byte_valid_i(byte_valid),
      .byte_i(byte_d), .index_x_i(index_x_i), .index_y_i(index_y_i), .acc_a_i(acc_a_i), .acc_b_i(acc_b_i),
      .branch_cond_i(branch_cond_i), .byte_ready_o(byte_ready), .done_o(done_o), .pc_o(pc_o), .ea_o(ea_o),
      .ea_valid_o(ea_valid_o), .mode_o(mode_o), .page_o(page_o), .length_o(length_o), .illegal_o(illegal_o),
      .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .index_x_o(index_x_o), .regs_we_o(regs_we_o));
   amd_mem_model amd_mem_model_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .pc_i(pc_o), .ready_i(byte_ready),
      .slow_i(slow), .valid_o(byte_valid), .byte_o(byte_d));
   task automatic complete_run();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         $display("Error at %0t: run did not finish", $time);
         complete_run();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // mode 0 means branch or page 3/4 prebyte: address is not checked, mode is checked as zero only for the prebyte case
   task automatic run(input logic [7:0] bb [0:4], input int n, input logic [5:0] mode, input logic [15:0] ea,
      input logic [1:0] page, input logic tk);
      int w;
      logic [15:0] nx;
      for (int k = 0; k < n; k++)
         amd_mem_model_inst.mem[16'(pc_exp + 16'(k))] = bb[k];
      nx = pc_exp + 16'(n) + (tk ? {{8{bb[n-1][7]}}, bb[n-1]} : 16'h0000);
      amd_mem_model_inst.left = n;
      for (w = 0; w < 40; w++)
      begin
         @(posedge sys_clk_i);
         #1;
         if (done_o === 1'b1)
            break;
      end
      chk(16'(w < 40), 16'h0001, "done");
      chk(16'(length_o), 16'(n), "length");
      chk(16'(page_o), 16'(page), "page");
      chk(16'(illegal_o), 16'(page > 2'd1), "illegal");
      chk(pc_o, nx, "pc");
      if (mode != 6'h00)
         chk(16'(mode_o), 16'(mode), "mode");
      if (page > 2'd1)
      begin
         chk(16'(mode_o), 16'h0000, "illegal mode");
         chk(16'(ea_valid_o), 16'h0000, "illegal ea_valid");
      end
      if (mode > 6'h02)
      begin
         chk(ea_o, ea, "ea");
         chk(16'(ea_valid_o), 16'h0001, "ea_valid");
      end
      if (mode == 6'h01)
      begin
         chk(16'(ea_valid_o), 16'h0000, "ea_valid");
         chk(16'(regs_we_o), 16'h0001, "regs_we");
         if (bb[0] == amd_op_add_accumulators)
            chk(16'(acc_a_o), 16'(8'(acc_a_i + acc_b_i)), "acc_a");
         if (bb[0] == amd_op_increment_acc_b)
            chk(16'(acc_b_o), 16'(8'(acc_b_i + 8'h01)), "acc_b");
         if (bb[0] == amd_op_increment_index_x)
            chk(index_x_o, 16'(index_x_i + 16'h0001), "index_x");
         if (bb[0] == amd_op_add_b_to_index_x)
            chk(index_x_o, 16'(index_x_i + {8'h00, acc_b_i}), "index_x abx");
      end
      pc_exp = nx;
   endtask : run
   task automatic step(input int kind, input int v, input logic [7:0] p, input logic [7:0] q,
      input logic [7:0] r, input logic c);
      logic [15:0] ex;
      logic [15:0] ey;
      logic [7:0] inherent_mode;
      ex = index_x_i + 16'(p);
      ey = index_y_i + 16'(p);
      inherent_mode = (v % 4 == 0) ? amd_op_add_accumulators : (v % 4 == 1) ? amd_op_increment_acc_b :
         (v % 4 == 2) ? amd_op_increment_index_x : amd_op_add_b_to_index_x;
      branch_cond_i = c;
      case (kind)
         0: run('{v[0] ? amd_op_std_idx : amd_op_ldd_idx, p, 8'h00, 8'h00, 8'h00}, 2, 6'h10, ex, 2'd0, 1'b0);
         1: run('{amd_pre_page2, amd_op_ldd_idx, p, 8'h00, 8'h00}, 3, 6'h20, ey, 2'd1, 1'b0);
         2: run('{v[0] ? amd_op_std_dir : amd_op_ldd_dir, p, 8'h00, 8'h00, 8'h00}, 2, 6'h04, {8'h00, p}, 2'd0,
            1'b0);
         3: run('{v[0] ? amd_op_std_ext : amd_op_ldd_ext, p, q, 8'h00, 8'h00}, 3, 6'h08, {p, q}, 2'd0, 1'b0);
         4: run('{amd_op_ldd_imm, p, q, 8'h00, 8'h00}, 3, 6'h02, 16'h0000, 2'd0, 1'b0);
         5: run('{inherent_mode, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 6'h01, 16'h0000, 2'd0, 1'b0);
         6: run('{{amd_branch_hi, 4'(v)}, p, 8'h00, 8'h00, 8'h00}, 2, 6'h00, 16'h0000, 2'd0, c);
         7: run('{v[0] ? amd_op_branch_if_bits_set_dir : amd_op_branch_if_bits_clear_dir, p, q, r, 8'h00}, 4, 6'h04, {8'h00, p}, 2'd0, c);
         8: run('{v[0] ? amd_op_branch_if_bits_set_idx : amd_op_branch_if_bits_clear_idx, p, q, r, 8'h00}, 4, 6'h10, ex, 2'd0, c);
         9: run('{amd_pre_page2, amd_op_branch_if_bits_set_idx, p, q, r}, 5, 6'h20, ey, 2'd1, c);
         10: run('{v[0] ? amd_op_bset_dir : amd_op_bclr_dir, p, q, 8'h00, 8'h00}, 3, 6'h04, {8'h00, p}, 2'd0,
            1'b0);
         11: run('{v[0] ? amd_op_bset_idx : amd_op_bclr_idx, p, q, 8'h00, 8'h00}, 3, 6'h10, ex, 2'd0,
            1'b0);
         12: run('{amd_pre_page2, amd_op_swap_d_with_x, 8'h00, 8'h00, 8'h00}, 2, 6'h01, 16'h0000, 2'd1,
            1'b0);
         default: run('{v[0] ? amd_pre_page3 : amd_pre_page4, amd_op_ldd_idx, p, 8'h00, 8'h00}, 3, 6'h00, 16'h0000,
            v[0] ? 2'd2 : 2'd3, 1'b0);
      endcase
   endtask : step
   initial
   begin
      void'($urandom(82));
      repeat (8) @(posedge sys_clk_i);
      #1 rstn_i = 1'b1;
      index_x_i = 16'hffff;
      step(0, 0, 8'hff, 8'h00, 8'h00, 1'b0);
      step(5, 2, 8'h00, 8'h00, 8'h00, 1'b0);
      step(6, 0, 8'hfe, 8'h00, 8'h00, 1'b1);
      step(6, 4, 8'h00, 8'h00, 8'h00, 1'b1);
      step(6, 7, 8'h00, 8'h00, 8'h00, 1'b0);
      step(6, 0, 8'h80, 8'h00, 8'h00, 1'b1);
      step(6, 0, 8'h7f, 8'h00, 8'h00, 1'b1);
      step(7, 1, 8'h40, 8'h01, 8'hfc, 1'b1);
      step(8, 0, 8'h10, 8'h80, 8'hfc, 1'b1);
      step(9, 0, 8'hff, 8'h02, 8'hfb, 1'b1);
      step(12, 0, 8'h00, 8'h00, 8'h00, 1'b0);
      step(13, 1, 8'h21, 8'h00, 8'h00, 1'b0);
      step(13, 0, 8'h42, 8'h00, 8'h00, 1'b0);
      // random mix, so a page-2 instruction is often followed by a page-1 one
      for (int i = 0; i < 400; i++)
      begin
         index_x_i = 16'($urandom());
         index_y_i = 16'($urandom());
         acc_a_i = 8'($urandom());
         acc_b_i = 8'($urandom());
         slow = 1'($urandom());
         step($urandom_range(0, 13), $urandom_range(0, 15), 8'($urandom()), 8'($urandom()), 8'($urandom()),
            1'($urandom()));
      end
      complete_run();
   end
endmodule : test_cpu_address_mode_decoder
